// ---- hdl/dpgc_gpio_config.sv ----
// Purpose: dual port link gpio and local gpio configuration registers
// Assumes: i2c slave logic outside decodes the two slave addresses
// Notes: one per-port copy of each link gpio config register
`timescale 1ns/1ps
module dpgc_gpio_config
#(
  parameter int NUM_PORTS = 2
)
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire dpgc_pkg::dpgc_req_t regReq,
  output logic [7:0] regRdata,
  input wire logic twoLaneMode,
  input wire logic [3:0] linkPinIn,
  input wire logic [3:0] linkPin2In,
  input wire logic [3:0] backSample,
  input wire logic backSampleValid,
  input wire logic [3:0] backSample2,
  input wire logic backSample2Valid,
  output dpgc_pkg::dpgc_link_t linkPort1,
  output dpgc_pkg::dpgc_link_t linkPort2,
  input wire logic [3:0] localPinIn,
  output logic [3:0] localPinOut,
  output logic [3:0] localPinOe_n,
  output logic [3:0] audioInMask
);
  import dpgc_pkg::*;

  logic [7:0] portSel_reg;
  logic [7:0] cfg0_reg [NUM_PORTS];
  logic [7:0] cfg12_reg [NUM_PORTS];
  logic [7:0] cfg3_reg [NUM_PORTS];
  logic [7:0] loc56_reg;
  logic [7:0] loc78_reg;
  logic [3:0] held_reg [NUM_PORTS];
  logic [7:0] rdata_next;
  logic [NUM_PORTS-1:0] wrPort;
  logic rdSecond;
  logic [3:0] locNib [LOCAL_GPIOS];
  logic [3:0] linkIn [NUM_PORTS];
  logic [3:0] bcIn [NUM_PORTS];
  logic [NUM_PORTS-1:0] bcValid;
  logic [NUM_PORTS-1:0] portOn;
  logic wrSel;
  logic wrCfg0;
  logic wrCfg12;
  logic wrCfg3;
  logic wrLoc56;
  logic wrLoc78;
  logic rdStrobe;

  // write strobes, one per register; the input level registers and
  // unmapped offsets decode to nothing, so writes there fall away
  always_comb
  begin
    wrSel = regReq.write && (regReq.addr == PORT_SEL_OFS);
    wrCfg0 = regReq.write && (regReq.addr == GPIO0_CFG_OFS);
    wrCfg12 = regReq.write && (regReq.addr == GPIO12_CFG_OFS);
    wrCfg3 = regReq.write && (regReq.addr == GPIO3_CFG_OFS);
    wrLoc56 = regReq.write && (regReq.addr == LOC56_CFG_OFS);
    wrLoc78 = regReq.write && (regReq.addr == LOC78_CFG_OFS);
    rdStrobe = regReq.read;
  end

  // port steering; the second address overrides the pick bits when bit 2 of the selector enables it
  // with neither pick bit set a read still shows the first copy,
  // so it never floats, but a write then lands in no port at all
  always_comb
  begin
    if (regReq.secondAddr && portSel_reg[SECOND_ADDR_EN_BIT])
    begin
      wrPort = 2'b10;
      rdSecond = 1'b1;
    end
    else
    begin
      wrPort[0] = portSel_reg[FIRST_PICK_BIT];
      wrPort[1] = portSel_reg[SECOND_PICK_BIT];
      rdSecond = portSel_reg[SECOND_PICK_BIT];
    end
  end

  // port selector register; shared, so its own pick bits never steer it
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      portSel_reg <= PORT_SEL_RST;
    else if (wrSel)
      portSel_reg <= regReq.wdata;
  end

  // duplicated link gpio config, one copy per port
  always_ff @(posedge ref_clk)
  begin
    for (int p = 0; p < NUM_PORTS; p++)
    begin
      if (rst)
      begin
        cfg0_reg[p] <= CFG_RST;
        cfg12_reg[p] <= CFG_RST;
        cfg3_reg[p] <= CFG_RST;
      end
      else
      begin
        // both copies load at the same edge when both ports are picked,
        // which keeps the two link gpio sets in step during bring-up
        if (wrCfg0 && wrPort[p])
        begin
          cfg0_reg[p] <= regReq.wdata;
        end
        if (wrCfg12 && wrPort[p])
        begin
          cfg12_reg[p] <= regReq.wdata;
        end
        if (wrCfg3 && wrPort[p])
        begin
          cfg3_reg[p] <= regReq.wdata;
        end
      end
    end
  end

  // shared local gpio config, reached from local or remote masters alike
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      loc56_reg <= CFG_RST;
      loc78_reg <= CFG_RST;
    end
    else
    begin
      // no copy goes to the far end; local state stays local
      if (wrLoc56)
      begin
        loc56_reg <= regReq.wdata;
      end
      if (wrLoc78)
      begin
        loc78_reg <= regReq.wdata;
      end
    end
  end

  // nibble views and per-port inputs
  always_comb
  begin
    locNib[0] = loc56_reg[3:0];
    locNib[1] = loc56_reg[7:4];
    locNib[2] = loc78_reg[3:0];
    locNib[3] = loc78_reg[7:4];
    linkIn[0] = linkPinIn;
    linkIn[1] = linkPin2In;
    bcIn[0] = backSample;
    bcIn[1] = backSample2;
    bcValid[0] = backSampleValid;
    bcValid[1] = backSample2Valid;
    portOn[0] = 1'b1;
    portOn[1] = twoLaneMode;
  end

  // latest back-channel sample, held between frames
  always_ff @(posedge ref_clk)
  begin
    for (int p = 0; p < NUM_PORTS; p++)
    begin
      if (rst)
        held_reg[p] <= 4'h0;
      else if (bcValid[p] && portOn[p])
        held_reg[p] <= bcIn[p];
    end
  end

  // link gpio pin control for both ports
  always_comb
  begin
    linkPort1 = '0;
    linkPort2 = '0;
    for (int p = 0; p < NUM_PORTS; p++)
    begin
      dpgc_link_t l;
      logic [3:0] n [LINK_GPIOS];
      l = '0;
      n[0] = cfg0_reg[p][3:0];
      n[1] = cfg12_reg[p][3:0];
      n[2] = cfg12_reg[p][7:4];
      n[3] = cfg3_reg[p][3:0];
      for (int g = 0; g < LINK_GPIOS; g++)
      begin
        // forward: sample pin and send; back: drive held sample
        if (portOn[p] && n[g] == CODE_FORWARD)
        begin
          l.fwdValid[g] = 1'b1;
          l.fwdData[g] = linkIn[p][g];
          l.pinOe[g] = 1'b1;
        end
        else if (portOn[p] && n[g] == CODE_BACK)
        begin
          l.pinOut[g] = held_reg[p][g];
          l.pinOe[g] = 1'b0;
        end
        else
          l.pinOe[g] = 1'b1;
      end
      if (p == 0)
        linkPort1 = l;
      else
        linkPort2 = l;
    end
  end

  // local gpios: register driven only, gpio mode masks the audio input
  always_comb
  begin
    for (int i = 0; i < LOCAL_GPIOS; i++)
    begin
      localPinOut[i] = (locNib[i] == CODE_LOCAL_HIGH);
      localPinOe_n[i] = !((locNib[i] == CODE_LOCAL_LOW) ||
                          (locNib[i] == CODE_LOCAL_HIGH));
      audioInMask[i] = (locNib[i] == CODE_LOCAL_LOW) ||
                       (locNib[i] == CODE_LOCAL_HIGH) ||
                       (locNib[i] == CODE_INPUT);
    end
  end

  // read mux
  always_comb
  begin
    int s;
    s = rdSecond ? 1 : 0;
    rdata_next = 8'h00;
    case (regReq.addr)
      GPIO0_CFG_OFS: rdata_next = cfg0_reg[s];
      GPIO12_CFG_OFS: rdata_next = cfg12_reg[s];
      GPIO3_CFG_OFS: rdata_next = cfg3_reg[s];
      LOC56_CFG_OFS: rdata_next = loc56_reg;
      LOC78_CFG_OFS: rdata_next = loc78_reg;
      IN_LEVELS_OFS:
      begin
        // gpio 0-3 at bits 3:0, bit 4 unused, 5-7 above
        rdata_next[3:0] = linkPinIn;
        rdata_next[4] = 1'b0;
        rdata_next[7:5] = localPinIn[2:0];
      end
      IN_GPIO8_OFS: rdata_next[0] = localPinIn[3];
      PORT_SEL_OFS: rdata_next = portSel_reg;
      default: rdata_next = 8'h00;
    endcase
  end

  // read data registered on a read request and held until the next one,
  // so a slow bus side may pick it up late
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      regRdata <= 8'h00;
    else if (rdStrobe)
      regRdata <= rdata_next;
  end
endmodule : dpgc_gpio_config

// ---- hdl/dpgc_pkg.sv ----
// Purpose: shared constants and types for the dual port gpio config block
// Assumes: byte-wide register file reached by a simple internal access port
// Notes: offsets are the printed register addresses
package dpgc_pkg;
  localparam logic [7:0] GPIO0_CFG_OFS = 8'h0D;
  localparam logic [7:0] GPIO12_CFG_OFS = 8'h0E;
  localparam logic [7:0] GPIO3_CFG_OFS = 8'h0F;
  localparam logic [7:0] LOC56_CFG_OFS = 8'h10;
  localparam logic [7:0] LOC78_CFG_OFS = 8'h11;
  localparam logic [7:0] IN_LEVELS_OFS = 8'h1C;
  localparam logic [7:0] IN_GPIO8_OFS = 8'h1D;
  localparam logic [7:0] PORT_SEL_OFS = 8'h1E;
  // port selector fields
  localparam int FIRST_PICK_BIT = 0;
  localparam int SECOND_PICK_BIT = 1;
  localparam int SECOND_ADDR_EN_BIT = 2;
  localparam logic [7:0] PORT_SEL_RST = 8'h01;
  localparam logic [7:0] CFG_RST = 8'h00;
  // configuration nibble codes
  localparam logic [3:0] CODE_LOCAL_LOW = 4'h1;
  localparam logic [3:0] CODE_LOCAL_HIGH = 4'h9;
  localparam logic [3:0] CODE_INPUT = 4'h3;
  localparam logic [3:0] CODE_FORWARD = 4'h3;
  localparam logic [3:0] CODE_BACK = 4'h5;
  localparam int LINK_GPIOS = 4;
  localparam int LOCAL_GPIOS = 4;

  // one register access as seen by the block
  typedef struct packed
  {
    logic read;
    logic write;
    logic secondAddr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dpgc_req_t;

  // per-port link gpio pin control
  typedef struct packed
  {
    logic [3:0] pinOut;
    logic [3:0] pinOe;
    logic [3:0] fwdData;
    logic [3:0] fwdValid;
  } dpgc_link_t;
endpackage : dpgc_pkg

// ---- dv/dpgc_gpio_config_properties.sv ----
// Purpose: port-level checks of the gpio config block
// Assumes: registered read data, one-cycle sample pulses
// Notes: bound into every instance of the block
`timescale 1ns/1ps
module dpgc_checker
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire dpgc_pkg::dpgc_req_t regReq,
  input wire logic [7:0] regRdata,
  input wire logic twoLaneMode,
  input wire logic [3:0] backSample,
  input wire logic backSampleValid,
  input wire dpgc_pkg::dpgc_link_t linkPort1,
  input wire dpgc_pkg::dpgc_link_t linkPort2,
  input wire logic [3:0] localPinOut,
  input wire logic [3:0] localPinOe_n,
  input wire logic [3:0] audioInMask
);
  import dpgc_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // read data stands until the next read
  AST_READ_STANDS:
    assert property (!regReq.read |=> $stable(regRdata))
    else $error("read data moved without a read");
  AST_UNMAPPED_ZERO:
    assert property (regReq.read && regReq.addr == 8'h00 |=> regRdata == 8'h00)
    else $error("unmapped read not zero");
  // only driven (back-channel) pins carry the sample
  AST_SAMPLE_TAKEN:
    assert property (backSampleValid && !regReq.write |=>
      (linkPort1.pinOut & ~linkPort1.pinOe) ==
      ($past(backSample) & ~linkPort1.pinOe))
    else $error("back sample not taken");
  AST_SAMPLE_HELD:
    assert property (!backSampleValid && !regReq.write |=>
      $stable(linkPort1.pinOut & ~linkPort1.pinOe))
    else $error("back sample not held");
  AST_PORT2_LANES:
    assert property (!twoLaneMode && !regReq.write |=>
      twoLaneMode || $stable(linkPort2.pinOut))
    else $error("port two moved in one-lane mode");
  AST_FWD_BACK_APART:
    assert property ((linkPort1.fwdValid & ~linkPort1.pinOe) == 4'h0)
    else $error("gpio both forward and back");
  AST_DRIVE_OWNS:
    assert property ((~localPinOe_n & ~audioInMask) == 4'h0)
    else $error("driven pin left to audio");
  AST_HIGH_ONLY_DRIVEN:
    assert property ((localPinOut & localPinOe_n) == 4'h0)
    else $error("high level on undriven pin");
endmodule : dpgc_checker

bind dpgc_gpio_config dpgc_checker chk (.*);

// ---- dv/dpgc_far_model.sv ----
// Purpose: far-end deserializer sending back-channel samples
// Assumes: one sample pulse every pace+1 cycles
// Notes: between pulses the sample lines toggle, never hold
`timescale 1ns/1ps
module dpgc_far_model
(
  input wire logic ref_clk,
  input wire logic [2:0] mode,
  input wire logic [7:0] pace,
  input wire logic [3:0] bits,
  output logic [3:0] sample,
  output logic sampleValid
);
  logic [7:0] cnt = 8'h00;
  // far end owns sampling mode and rate; fast modes carry fewer gpios
  always_ff @(posedge ref_clk)
  begin
    cnt <= (cnt >= pace) ? 8'h00 : cnt + 8'h01;
    sampleValid <= (cnt == pace);
    if (cnt != pace)
      sample <= ~sample;
    else if (mode == 3'b010)
      sample <= {2'b00, bits[1:0]};
    else if (mode == 3'b001)
      sample <= {3'b000, bits[0]};
    else
      sample <= bits;
  end
endmodule : dpgc_far_model

// ---- dv/tb_dual_port_gpio_config.sv ----
// Purpose: self-checking bench for the dual port gpio config block
// Assumes: one idle cycle between register accesses
// Notes: both link ports see the same far-end samples
`timescale 1ns/1ps
module tb_dual_port_gpio_config;
  import dpgc_pkg::*;
  `define CHK(n, e, a) begin n_compared++; if ((a) !== (e)) begin \
    failures++; $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic twoLaneMode = 1'b0;
  logic [3:0] linkPinIn = 4'hA;
  logic [3:0] localPinIn = 4'hC;
  logic [3:0] fb = 4'h2;
  logic [3:0] smp, pOut, pOe_n, mask;
  logic smpV;
  logic [7:0] rdata;
  dpgc_req_t regReq = '0;
  dpgc_link_t lp1, lp2;
  int failures = 0;
  int n_compared = 0;
  // clock, far end and the block
  always #2 ref_clk = ~ref_clk;
  dpgc_far_model far (.ref_clk(ref_clk), .mode(3'b011), .pace(8'h07),
    .bits(fb), .sample(smp), .sampleValid(smpV));
  dpgc_gpio_config dut (.ref_clk(ref_clk), .rst(rst), .regReq(regReq),
    .regRdata(rdata), .twoLaneMode(twoLaneMode), .linkPinIn(linkPinIn),
    .linkPin2In(linkPinIn), .backSample(smp), .backSampleValid(smpV),
    .backSample2(smp), .backSample2Valid(smpV), .linkPort1(lp1),
    .linkPort2(lp2), .localPinIn(localPinIn), .localPinOut(pOut),
    .localPinOe_n(pOe_n), .audioInMask(mask));
  // one access held across one rising edge; idle edge avoids a re-drive
  task automatic acc(input bit w, input logic [7:0] a, d, input bit s);
    @(negedge ref_clk);
    regReq = {~w, w, s, a, d};
    @(negedge ref_clk);
    regReq = '0;
  endtask : acc
  task automatic rd(input logic [7:0] a, input bit s, input logic [7:0] e);
    acc(1'b0, a, 8'h00, s);
    `CHK("read data", e, rdata)
  endtask : rd
  // bounded wait for a sample pulse, then let it land
  task automatic wait_smp();
    int i;
    for (i = 0; i < 100 && smpV !== 1'b1; i++)
      @(negedge ref_clk);
    if (i == 100)
    begin
      failures++;
      print_verdict();
    end
    @(negedge ref_clk);
  endtask : wait_smp
  task automatic t_reset();
    rd(PORT_SEL_OFS, 1'b0, PORT_SEL_RST);
    rd(GPIO0_CFG_OFS, 1'b0, CFG_RST);
    rd(8'h00, 1'b0, 8'h00);
  endtask : t_reset
  task automatic t_ports();
    acc(1'b1, GPIO0_CFG_OFS, 8'h03, 1'b0);
    acc(1'b1, PORT_SEL_OFS, 8'h02, 1'b0);
    acc(1'b1, GPIO0_CFG_OFS, 8'h05, 1'b0);
    rd(GPIO0_CFG_OFS, 1'b0, 8'h05);
    acc(1'b1, PORT_SEL_OFS, 8'h03, 1'b0);
    rd(GPIO0_CFG_OFS, 1'b0, 8'h05);
    acc(1'b1, GPIO12_CFG_OFS, 8'h35, 1'b0);
    acc(1'b1, LOC56_CFG_OFS, 8'h91, 1'b0);
    acc(1'b1, PORT_SEL_OFS, 8'h01, 1'b0);
    rd(GPIO0_CFG_OFS, 1'b0, 8'h03);
    rd(GPIO12_CFG_OFS, 1'b0, 8'h35);
    rd(LOC56_CFG_OFS, 1'b0, 8'h91);
    `CHK("port one forward", 4'h5, lp1.fwdValid)
    `CHK("port one drive", 4'hD, lp1.pinOe)
    linkPinIn = 4'h5;
    @(negedge ref_clk);
    `CHK("port one data", 4'h5, lp1.fwdData)
    linkPinIn = 4'hA;
  endtask : t_ports
  task automatic t_second();
    acc(1'b1, PORT_SEL_OFS, 8'h05, 1'b0);
    acc(1'b1, GPIO3_CFG_OFS, 8'h05, 1'b1);
    rd(GPIO3_CFG_OFS, 1'b1, 8'h05);
    rd(GPIO3_CFG_OFS, 1'b0, 8'h00);
    acc(1'b1, PORT_SEL_OFS, 8'h01, 1'b0);
    acc(1'b1, GPIO3_CFG_OFS, 8'h03, 1'b1);
    rd(GPIO3_CFG_OFS, 1'b0, 8'h03);
  endtask : t_second
  task automatic t_local();
    acc(1'b1, LOC78_CFG_OFS, 8'h33, 1'b0);
    acc(1'b1, IN_GPIO8_OFS, 8'hFF, 1'b0);
    `CHK("local level", 4'h2, pOut)
    `CHK("local drive", 4'hC, pOe_n)
    `CHK("audio mask", 4'hF, mask)
    acc(1'b0, IN_LEVELS_OFS, 8'h00, 1'b0);
    `CHK("input levels", 8'h8A, rdata & 8'h9F)
    rd(IN_GPIO8_OFS, 1'b1, 8'h01);
  endtask : t_local
  task automatic t_back();
    wait_smp();
    `CHK("port one pin", 4'h2, lp1.pinOut & 4'h2)
    `CHK("port two pin", 4'h0, lp2.pinOut)
    twoLaneMode = 1'b1;
    fb = 4'h1;
    wait_smp();
    `CHK("port one pin", 4'h0, lp1.pinOut & 4'h2)
    `CHK("port two pin", 4'h1, lp2.pinOut & 4'h3)
    `CHK("port two forward", 4'h4, lp2.fwdValid)
  endtask : t_back
  task automatic print_verdict();
    if (failures == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  // reset for three cycles, then the scenarios in turn
  initial
  begin
    repeat (3) @(negedge ref_clk);
    rst = 1'b0;
    t_reset();
    t_ports();
    t_second();
    t_local();
    t_back();
    print_verdict();
  end
endmodule : tb_dual_port_gpio_config
